// ---- core/pulse_cfg_pkg.sv ----
// Constants and types shared by the command pulse conditioning block
package pulse_cfg_pkg;
  // Register port and field widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CFG_W = 3;
  localparam int NUM_W = 3;
  localparam int DEN_W = 6;
  localparam int POS_W = 32;
  // Register word addresses
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_DIV_NUM = 4'h1;
  localparam logic [3:0] ADDR_DIV_DEN = 4'h2;
  localparam logic [3:0] ADDR_MODE = 4'h3;
  localparam logic [3:0] ADDR_RESTART = 4'h4;
  localparam logic [3:0] ADDR_ACTIVE = 4'h5;
  localparam logic [3:0] ADDR_POSITION = 4'h6;
  // Fields of the pulse configuration value
  localparam int CFG_EDGE_BIT = 2;
  localparam int CFG_INV_BIT = 1;
  localparam int CFG_ALT_BIT = 0;
  // Fields of the active settings read-back word
  localparam int ACT_CFG_LSB = 0;
  localparam int ACT_MODE_BIT = 3;
  localparam int ACT_DEN_LSB = 4;
  localparam int ACT_NUM_LSB = 10;
  // Reset values and legal ranges
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [2:0] NUM_RESET = 3'h1;
  localparam logic [2:0] NUM_FIXED = 3'h1;
  localparam int NUM_MIN = 1;
  localparam int NUM_MAX = 7;
  localparam logic [5:0] DEN_RESET = 6'h01;
  localparam int DEN_MIN = 1;
  localparam int DEN_MAX = 32;
  // Command input form
  typedef enum logic {MODE_PULSE_DIR, MODE_TWO_PHASE} cmd_mode_t;
  localparam cmd_mode_t MODE_RESET = MODE_PULSE_DIR;
endpackage

// ---- core/pulse_cfg_if.sv ----
// Active settings passed from the control core to the pulse datapaths
interface pulse_cfg_if;
  import pulse_cfg_pkg::*;
  logic [CFG_W-1:0] cfg;
  cmd_mode_t mode;
  logic [DEN_W-1:0] den;
  logic run;
  modport src(output cfg, output mode, output den, output run);
  modport sink(input cfg, input mode, input den, input run);
endinterface

// ---- core/cmd_pulse_decoder.sv ----
// Command pulse edge, polarity and direction decoder
module cmd_pulse_decoder
  import pulse_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Settings
  pulse_cfg_if.sink cfg,
  // Command pins
  input wire logic pulse_i,
  input wire logic dir_i,
  // Step output
  output logic step_o,
  output logic up_o
);
  typedef struct packed {
    logic pulse_q;
    logic primed;
    logic step;
    logic up;
  } dec_state_t;

  dec_state_t st;
  dec_state_t next_st;
  logic lvl;
  logic hit;
  logic fall_sel;
  logic alt;

  always_comb begin
    fall_sel = cfg.cfg[CFG_EDGE_BIT];
    alt = cfg.cfg[CFG_ALT_BIT];
    lvl = pulse_i ^ cfg.cfg[CFG_INV_BIT];
    hit = fall_sel ? (~lvl & st.pulse_q) : (lvl & ~st.pulse_q);
    next_st = st;
    next_st.pulse_q = lvl;
    next_st.primed = cfg.run;
    next_st.step = hit & st.primed & cfg.run;
    if (cfg.mode == MODE_TWO_PHASE) begin
      // direction from phase B at phase A edge
      next_st.up = (dir_i == fall_sel) ^ alt;
    end else begin
      next_st.up = dir_i ^ alt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign step_o = st.step;
  assign up_o = st.up;

  chk_rise_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.primed && cfg.run && !fall_sel &&
     $rose(pulse_i ^ cfg.cfg[CFG_INV_BIT])) |=> step_o)
    else $error("rising command edge not counted");
  chk_fall_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.primed && cfg.run && fall_sel &&
     $fell(pulse_i ^ cfg.cfg[CFG_INV_BIT])) |=> step_o)
    else $error("falling command edge not counted");
  chk_pulse_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step_o && cfg.mode == MODE_PULSE_DIR) |->
    up_o == ($past(dir_i) ^ alt))
    else $error("pulse and direction sense wrong");
  chk_two_phase: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step_o && cfg.mode == MODE_TWO_PHASE) |->
    up_o == (($past(dir_i) == fall_sel) ^ alt))
    else $error("two phase direction wrong");
endmodule

// ---- core/enc_pulse_divider.sv ----
// Integer divider for the reproduced encoder pulse
module enc_pulse_divider
  import pulse_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Settings
  pulse_cfg_if.sink cfg,
  // Encoder pulse in and out
  input wire logic enc_i,
  output logic enc_o
);
  typedef struct packed {
    logic enc_q;
    logic primed;
    logic [DEN_W-1:0] cnt;
    logic out;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic edge_seen;

  always_comb begin
    edge_seen = (enc_i ^ st.enc_q) & st.primed & cfg.run;
    next_st = st;
    next_st.enc_q = enc_i;
    next_st.primed = cfg.run;
    if (!cfg.run) begin
      next_st.cnt = '0;
      next_st.out = 1'b0;
    end else if (edge_seen) begin
      if (st.cnt == cfg.den - 6'h01) begin
        next_st.cnt = '0;
        next_st.out = ~st.out;
      end else begin
        next_st.cnt = st.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign enc_o = st.out;

  chk_out_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg.run && $past(cfg.run) && $changed(enc_o)) |->
    $past(edge_seen) &&
    $past(st.cnt) == $past(cfg.den) - 6'h01)
    else $error("divided pulse toggled without full count");
  chk_cnt_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg.run |-> st.cnt < cfg.den)
    else $error("divider count beyond denominator");
endmodule

// ---- core/pulse_input_config_divider.sv ----
// Command pulse conditioning and encoder pulse divider, top level
// Behaviour
// - Config bits select edge, inversion, convention
// - Alternate convention for some host models
// - Encoder out equals input over denominator
// - Numerator ignored, treated as one
// - Two-phase: A on pulse, B on direction
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module pulse_input_config_divider
  import pulse_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  // Register port
  input wire logic [pulse_cfg_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pulse_cfg_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pulse_cfg_pkg::DATA_W-1:0] RDATA_O,
  // Command pins from the host
  input wire logic COMMAND_PULSE_INPUT_I,
  input wire logic COMMAND_DIR_I,
  // Encoder feedback
  input wire logic ENC_PULSE_I,
  output logic ENC_PULSE_O,
  // Decoded command
  output logic STEP_O,
  output logic STEP_UP_O,
  output logic RUN_O
);
  import pulse_cfg_pkg::*;

  typedef enum logic {ST_LATCH, ST_RUN} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [CFG_W-1:0] pend_cfg;
    logic [NUM_W-1:0] pend_num;
    logic [DEN_W-1:0] pend_den;
    cmd_mode_t pend_mode;
    logic [CFG_W-1:0] act_cfg;
    logic [DEN_W-1:0] act_den;
    cmd_mode_t act_mode;
    logic [POS_W-1:0] position;
    logic [DATA_W-1:0] rdata;
  } top_state_t;

  localparam top_state_t ST_RESET = '{
    phase: ST_LATCH,
    pend_cfg: CFG_RESET,
    pend_num: NUM_RESET,
    pend_den: DEN_RESET,
    pend_mode: MODE_RESET,
    act_cfg: CFG_RESET,
    act_den: DEN_RESET,
    act_mode: MODE_RESET,
    position: '0,
    rdata: '0
  };

  top_state_t st;
  top_state_t next_st;
  logic dec_step;
  logic dec_up;
  logic den_ok;
  logic num_ok;
  logic [DATA_W-1:0] active_word;

  pulse_cfg_if cfg_bus ();

  assign cfg_bus.cfg = st.act_cfg;
  assign cfg_bus.mode = st.act_mode;
  assign cfg_bus.den = st.act_den;
  assign cfg_bus.run = (st.phase == ST_RUN);

  cmd_pulse_decoder u_decoder (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESET_N_I),
    .cfg(cfg_bus.sink),
    .pulse_i(COMMAND_PULSE_INPUT_I),
    .dir_i(COMMAND_DIR_I),
    .step_o(dec_step),
    .up_o(dec_up)
  );

  enc_pulse_divider u_divider (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESET_N_I),
    .cfg(cfg_bus.sink),
    .enc_i(ENC_PULSE_I),
    .enc_o(ENC_PULSE_O)
  );

  always_comb begin
    den_ok = (WDATA_I >= 32'(DEN_MIN)) && (WDATA_I <= 32'(DEN_MAX));
    num_ok = (WDATA_I >= 32'(NUM_MIN)) && (WDATA_I <= 32'(NUM_MAX));
    active_word = '0;
    active_word[ACT_CFG_LSB +: CFG_W] = st.act_cfg;
    active_word[ACT_MODE_BIT] = st.act_mode;
    active_word[ACT_DEN_LSB +: DEN_W] = st.act_den;
    // numerator field of the active word always reads back as one
    active_word[ACT_NUM_LSB +: NUM_W] = NUM_FIXED;
    next_st = st;
    next_st.rdata = '0;
    case (st.phase)
      ST_LATCH: begin
        next_st.act_cfg = st.pend_cfg;
        next_st.act_den = st.pend_den;
        next_st.act_mode = st.pend_mode;
        next_st.position = '0;
        next_st.phase = ST_RUN;
      end
      ST_RUN: begin
        if (dec_step) begin
          if (dec_up) begin
            next_st.position = st.position + 32'h00000001;
          end else begin
            next_st.position = st.position - 32'h00000001;
          end
        end
      end
      default: begin
        next_st.phase = ST_LATCH;
      end
    endcase
    if (WR_I) begin
      case (ADDR_I)
        ADDR_CFG: begin
          // value chosen to match the host form
          next_st.pend_cfg = WDATA_I[CFG_W-1:0];
        end
        ADDR_DIV_NUM: begin
          if (num_ok) begin
            next_st.pend_num = WDATA_I[NUM_W-1:0];
          end
        end
        ADDR_DIV_DEN: begin
          // out of range keeps the last value
          if (den_ok) begin
            next_st.pend_den = WDATA_I[DEN_W-1:0];
          end
        end
        ADDR_MODE: begin
          next_st.pend_mode = cmd_mode_t'(WDATA_I[0]);
        end
        ADDR_RESTART: begin
          next_st.phase = ST_LATCH;
        end
        default: begin
        end
      endcase
    end
    if (RD_I) begin
      case (ADDR_I)
        ADDR_CFG: next_st.rdata = {29'h0, st.pend_cfg};
        ADDR_DIV_NUM: next_st.rdata = {29'h0, st.pend_num};
        ADDR_DIV_DEN: next_st.rdata = {26'h0, st.pend_den};
        ADDR_MODE: next_st.rdata = {31'h0, st.pend_mode};
        ADDR_ACTIVE: next_st.rdata = active_word;
        ADDR_POSITION: next_st.rdata = st.position;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O = st.rdata;
  assign STEP_O = dec_step;
  assign STEP_UP_O = dec_up;
  assign RUN_O = (st.phase == ST_RUN);

  chk_act_latch: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    ($changed(st.act_cfg) || $changed(st.act_den) ||
     $changed(st.act_mode)) |-> $past(st.phase) == ST_LATCH)
    else $error("active settings changed outside restart");
  chk_latch_copy: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (st.phase == ST_LATCH) |=> st.act_cfg == $past(st.pend_cfg) &&
    st.act_den == $past(st.pend_den) && RUN_O ||
    $past(WR_I && ADDR_I == ADDR_RESTART))
    else $error("restart did not copy pending settings");
  chk_den_range: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    st.pend_den >= 6'(DEN_MIN) && st.pend_den <= 6'(DEN_MAX))
    else $error("denominator outside legal range");
  chk_num_one: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (RD_I && ADDR_I == ADDR_ACTIVE) |=>
    RDATA_O[ACT_NUM_LSB +: NUM_W] == NUM_FIXED)
    else $error("active numerator not one");
  chk_pos_step: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (RUN_O && STEP_O && !(WR_I && ADDR_I == ADDR_RESTART)) |=>
    st.position == $past(st.position) +
    ($past(STEP_UP_O) ? 32'h00000001 : 32'hFFFFFFFF))
    else $error("position did not follow step");
  chk_pos_read: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (RD_I && ADDR_I == ADDR_POSITION) |=>
    RDATA_O == $past(st.position))
    else $error("position read-back wrong");
  chk_restart_stop: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (WR_I && ADDR_I == ADDR_RESTART) |=> !RUN_O)
    else $error("restart did not stop the datapaths");
  chk_latch_run: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (!RUN_O && !(WR_I && ADDR_I == ADDR_RESTART)) |=> RUN_O)
    else $error("latch phase did not end in run");
  chk_pos_clear: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    !RUN_O |=> st.position == '0)
    else $error("position not cleared at restart");
  chk_mode_copy: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    !RUN_O |=> st.act_mode == $past(st.pend_mode))
    else $error("command mode not copied at restart");
  chk_cfg_store: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (WR_I && ADDR_I == ADDR_CFG) |=>
    st.pend_cfg == $past(WDATA_I[CFG_W-1:0]))
    else $error("configuration write not stored");
  chk_mode_store: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (WR_I && ADDR_I == ADDR_MODE) |=>
    st.pend_mode == $past(WDATA_I[0]))
    else $error("mode write not stored");
  chk_den_store: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (WR_I && ADDR_I == ADDR_DIV_DEN && WDATA_I >= 32'(DEN_MIN) &&
     WDATA_I <= 32'(DEN_MAX)) |=>
    st.pend_den == $past(WDATA_I[DEN_W-1:0]))
    else $error("legal denominator not stored");
  chk_den_keep: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (WR_I && ADDR_I == ADDR_DIV_DEN && (WDATA_I < 32'(DEN_MIN) ||
     WDATA_I > 32'(DEN_MAX))) |=> $stable(st.pend_den))
    else $error("illegal denominator was stored");
  chk_num_keep: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (WR_I && ADDR_I == ADDR_DIV_NUM && (WDATA_I < 32'(NUM_MIN) ||
     WDATA_I > 32'(NUM_MAX))) |=> $stable(st.pend_num))
    else $error("illegal numerator was stored");
  chk_act_read: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (RD_I && ADDR_I == ADDR_ACTIVE) |=>
    RDATA_O[ACT_CFG_LSB +: CFG_W] == $past(st.act_cfg) &&
    RDATA_O[ACT_DEN_LSB +: DEN_W] == $past(st.act_den))
    else $error("active settings read-back wrong");
  chk_rdata_idle: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    !RD_I |=> RDATA_O == '0)
    else $error("read data present without a read");
  chk_step_single: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    STEP_O |=> !STEP_O)
    else $error("step longer than one cycle");
  chk_step_idle: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    !RUN_O |=> !STEP_O)
    else $error("step while settings latch");
  chk_step_prime: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    $rose(RUN_O) |=> !STEP_O)
    else $error("step in first running cycle");
  chk_pos_hold: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (RUN_O && !STEP_O) |=> $stable(st.position))
    else $error("position moved without a step");
  chk_enc_idle: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    !RUN_O |=> !ENC_PULSE_O)
    else $error("divided pulse not cleared at restart");
  chk_enc_follow: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    (RUN_O && $past(RUN_O) && st.act_den == 6'h01 &&
     $changed(ENC_PULSE_I)) |=> $changed(ENC_PULSE_O))
    else $error("unit divider did not follow input");
endmodule

// ---- verification/host_model.sv ----
// Host controller model issuing command pulses
module host_model (
  // Clock and request
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic two_phase_i,
  input wire logic fwd_i,
  // Command lines
  output logic pulse_o,
  output logic dir_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] seq [4];
  initial begin
    pulse_o = 1'b0;
    dir_o = 1'b0;
    busy_o = 1'b0;
  end
  // A on pulse, B on direction
  always @(posedge clk_i) begin
    if (req_i) begin
      busy_o <= 1'b1;
      if (two_phase_i && fwd_i) seq = '{2'h2, 2'h3, 2'h1, 2'h0};
      else if (two_phase_i) seq = '{2'h1, 2'h3, 2'h2, 2'h0};
      else seq = '{{1'b0, fwd_i}, {1'b1, fwd_i}, {1'b0, fwd_i}, {1'b0, fwd_i}};
      for (int i = 0; i < 4; i++) begin
        {pulse_o, dir_o} <= seq[i];
        repeat (3) @(posedge clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the command pulse and encoder divider block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pulse_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic pulse, dir, busy, req = 1'b0, two = 1'b0, fwd = 1'b0;
  logic enc_in = 1'b0, enc_out, step, up, run, enc_q = 1'b0;
  int mismatches = 0, n_tests = 0, steps = 0, ups = 0, encs = 0;

  always #12.5 clk = ~clk;

  pulse_input_config_divider pulse_input_config_divider_inst (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .COMMAND_PULSE_INPUT_I(pulse), .COMMAND_DIR_I(dir),
    .ENC_PULSE_I(enc_in), .ENC_PULSE_O(enc_out),
    .STEP_O(step), .STEP_UP_O(up), .RUN_O(run));

  host_model host_model_inst (.clk_i(clk), .req_i(req),
    .two_phase_i(two), .fwd_i(fwd), .pulse_o(pulse), .dir_o(dir),
    .busy_o(busy));

  always @(posedge clk) begin
    if (step === 1'b1) steps++;
    if (step === 1'b1 && up === 1'b1) ups++;
    if (enc_out !== enc_q) encs++;
    enc_q <= enc_out;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wrr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdc(string nm, logic [3:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask

  task automatic apply(logic [2:0] c, logic m, logic [5:0] dv);
    wrr(ADDR_CFG, {29'h0, c});
    wrr(ADDR_MODE, {31'h0, m});
    wrr(ADDR_DIV_DEN, {26'h0, dv});
    wrr(ADDR_RESTART, 32'h0);
    repeat (5) @(posedge clk);
    chk("run", 32'h1, {31'h0, run});
  endtask

  task automatic t_reset();
    chk("run", 32'h1, {31'h0, run});
    rdc("active", ADDR_ACTIVE, 32'h0000_0410);
    rdc("cfg", ADDR_CFG, 32'h0);
    rdc("num", ADDR_DIV_NUM, 32'h1);
    rdc("den", ADDR_DIV_DEN, 32'h1);
    rdc("pos", ADDR_POSITION, 32'h0);
  endtask

  task automatic t_latch();
    wrr(ADDR_CFG, 32'h5);
    wrr(ADDR_DIV_NUM, 32'h5);
    wrr(ADDR_DIV_NUM, 32'h8);
    wrr(ADDR_DIV_DEN, 32'h21);
    wrr(ADDR_DIV_DEN, 32'h0);
    wrr(ADDR_POSITION, 32'h7);
    rdc("active", ADDR_ACTIVE, 32'h0000_0410);
    rdc("den", ADDR_DIV_DEN, 32'h1);
    rdc("num", ADDR_DIV_NUM, 32'h5);
    rdc("unmapped", 4'h9, 32'h0);
    wrr(ADDR_RESTART, 32'h0);
    repeat (4) @(posedge clk);
    rdc("active", ADDR_ACTIVE, 32'h0000_0415);
    rdc("pos", ADDR_POSITION, 32'h0);
  endtask

  task automatic t_cmd(logic [2:0] c, logic m, logic f);
    int e;
    apply(c, m, 6'h01);
    steps = 0;
    ups = 0;
    two <= m;
    fwd <= f;
    repeat (3) begin
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 40 && busy; i++) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    e = (f ^ c[CFG_ALT_BIT]) ? 3 : -3;
    chk("steps", 32'h3, steps);
    chk("ups", (e > 0) ? 32'h3 : 32'h0, ups);
    rdc("pos", ADDR_POSITION, e);
  endtask

  task automatic t_enc(logic [5:0] dv, int n);
    apply(3'h0, 1'b0, dv);
    encs = 0;
    repeat (n) begin
      enc_in <= ~enc_in;
      repeat (2) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    chk("enc", n / dv, encs);
  endtask

  task automatic final_report();
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(25 * 30000);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_latch();
    for (int c = 0; c < 8; c++) t_cmd(c[2:0], 1'b0, c[1]);
    for (int c = 0; c < 8; c++) begin
      if (!c[1]) t_cmd(c[2:0], 1'b1, c[2] ^ c[0]);
    end
    t_enc(6'h01, 8);
    t_enc(6'h03, 12);
    t_enc(6'h20, 64);
    final_report();
  end
endmodule
